// *** core/cxa_pkg.sv ***
package cxa_pkg;
   // ==========================================================
   // value identifiers and lengths
   localparam logic [7:0] ID_ENABLE    = 8'h31;
   localparam logic [7:0] ID_OPTIONS   = 8'h32;
   localparam logic [7:0] ID_PERIODIC  = 8'h35;
   localparam logic [7:0] ID_DIR_PULSE = 8'h36;
   localparam logic [2:0] LEN_ENABLE   = 3'h1;
   localparam logic [2:0] LEN_OPTIONS  = 3'h4;
   localparam logic [2:0] LEN_PERIODIC = 3'h3;
   localparam logic [2:0] LEN_DIR      = 3'h1;
   localparam logic       STATUS_OK    = 1'b0;
   localparam logic       STATUS_ERR   = 1'b1;
   // ==========================================================
   // options word fields
   localparam int OPT_RETRY_LSB  = 0;
   localparam int OPT_RETRY_W    = 8;
   localparam int OPT_ACK_DIS    = 8;
   localparam int OPT_ABORT      = 9;
   localparam int OPT_TX_HI      = 10;
   localparam int OPT_RX_HI      = 11;
   localparam int OPT_RETRY_HI   = 12;
   localparam int OPT_RETRY_EN   = 13;
   localparam int OPT_HOLDOFF_IN = 14;
   localparam int OPT_FORCE_HOLD = 16;
   localparam int OPT_MAC_HOLD   = 17;
   localparam int OPT_ASSERT_LSB = 18;
   localparam int OPT_CCA_TH_LSB = 20;
   localparam int OPT_MAC_TH_LSB = 25;
   localparam logic [31:0] OPT_WRITABLE = 32'h067F7FFF;
   localparam logic [31:0] OPT_RESET    = 32'h00000000;
   localparam logic [1:0] ASSERT_SYNC   = 2'h0;
   localparam logic [1:0] ASSERT_SPLIT  = 2'h2;
   // ==========================================================
   // periodic request and pulse values
   localparam logic [7:0]  MODE_OFF     = 8'h00;
   localparam logic [7:0]  MODE_LOW     = 8'h80;
   localparam logic [7:0]  MODE_HIGH    = 8'h82;
   localparam logic [7:0]  DUTY_MIN     = 8'h05;
   localparam logic [7:0]  DUTY_MAX     = 8'h5F;
   localparam logic [7:0]  PERIOD_MIN   = 8'h0A;
   localparam logic [7:0]  PERIOD_MAX   = 8'hDA;
   localparam logic [15:0] PERCENT_FULL = 16'h0064;
   localparam logic [7:0]  DIR_RESET    = 8'h00;
   // ==========================================================
   // timing
   localparam int CLK_NS         = 25;
   localparam int HALF_MS_NS     = 500000;
   localparam int US_NS          = 1000;
   localparam int HALF_MS_CYCLES = HALF_MS_NS / CLK_NS;
   localparam int US_CYCLES      = US_NS / CLK_NS;
   localparam logic [5:0] US_LAST = 6'(US_CYCLES - 1);
   // ==========================================================
   // directional pulse sequencer
   typedef enum logic [1:0] {
      DP_IDLE   = 2'b00,
      DP_ACTIVE = 2'b01,
      DP_DONE   = 2'b11
   } cxa_dp_state_t;
endpackage

// *** core/cxa_cfg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface cxa_cfg_if;
   logic [7:0] mode;
   logic [7:0] duty;
   logic [7:0] period;
   logic       run;
   logic       pwmReq;
   logic       pwmHigh;
   modport cfg (output mode, output duty, output period, output run,
                input pwmReq, input pwmHigh);
   modport gen (input mode, input duty, input period, input run,
                output pwmReq, output pwmHigh);
endinterface
`default_nettype wire

// *** core/cxa_pwm_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module cxa_pwm_gen #(
   parameter int unsigned STEP_CYCLES = cxa_pkg::HALF_MS_CYCLES
) (
   input  wire logic clk,
   input  wire logic reset_n,
   cxa_cfg_if.gen    cfg
);
   import cxa_pkg::*;

   localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

   logic [15:0] preQ, preD;
   logic [7:0]  posQ, posD;
   logic        reqQ, reqD;
   logic        hiQ,  hiD;
   logic        active;

   assign active = cfg.run && (cfg.mode != MODE_OFF);

   // ==========================================================
   // half-ms steps through one period
   always_comb begin
      preD = preQ;
      posD = posQ;
      if (!active) begin
         preD = '0;
         posD = '0;
      end else if (preQ == STEP_LAST) begin
         preD = '0;
         posD = (posQ >= cfg.period - 8'h01) ? 8'h00 : posQ + 8'h01;
      end else begin
         preD = preQ + 16'h0001;
      end
      // on while elapsed share stays under the duty share
      reqD = active && ((16'(posQ) * PERCENT_FULL)
                        < (16'(cfg.duty) * 16'(cfg.period)));
      hiD  = reqD && (cfg.mode == MODE_HIGH);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         preQ <= '0;
         posQ <= '0;
         reqQ <= 1'b0;
         hiQ  <= 1'b0;
      end else begin
         preQ <= preD;
         posQ <= posD;
         reqQ <= reqD;
         hiQ  <= hiD;
      end
   end

   assign cfg.pwmReq  = reqQ;
   assign cfg.pwmHigh = hiQ;

   a_pwm_off_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      !active |=> !reqQ && !hiQ) else $error("periodic request while off");
   a_pwm_start_on: assert property (@(posedge clk) disable iff (!reset_n)
      active && posQ == 8'h00 && cfg.duty != 8'h00 && cfg.period != 8'h00
      |=> reqQ) else $error("periodic request not on at period start");
   a_pwm_high_mode: assert property (@(posedge clk) disable iff (!reset_n)
      hiQ |-> reqQ && $past(cfg.mode) == MODE_HIGH)
      else $error("high periodic priority outside high mode");
   c_pwm_high: cover property (@(posedge clk) disable iff (!reset_n)
      reqQ && hiQ);
endmodule
`default_nettype wire

// *** core/cxa_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module cxa_top #(
   parameter int unsigned HALF_MS_CYCLES = cxa_pkg::HALF_MS_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        cmdValid,
   input  wire logic        cmdWrite,
   input  wire logic [7:0]  cmdId,
   input  wire logic [2:0]  cmdLen,
   input  wire logic [31:0] cmdData,
   output var  logic        rspValid,
   output var  logic        rspStatus,
   output var  logic [2:0]  rspLen,
   output var  logic [31:0] rspData,
   input  wire logic        grantPin,
   input  wire logic        radioHoldOffPin,
   input  wire logic        reqSecured,
   input  wire logic        txPending,
   input  wire logic        txActive,
   input  wire logic        rxSync,
   input  wire logic        rxAddrMatch,
   input  wire logic        rxEnd,
   input  wire logic        rxRetry,
   input  wire logic        ccaFail,
   input  wire logic        macFail,
   input  wire logic        txDone,
   output var  logic        requestOut,
   output var  logic        priorityOut,
   output var  logic        dirPulseOut,
   output var  logic        ackSuppress,
   output var  logic        txAbort,
   output var  logic        macHoldOff,
   output var  logic [7:0]  retryTimeoutMs
);
   import cxa_pkg::*;

   function automatic logic reached(input logic [2:0] cnt,
                                    input logic [2:0] th);
      reached = (th != 3'h0) && (cnt >= th);
   endfunction

   function automatic logic periodicOk(input logic [23:0] v);
      logic [7:0] m;
      logic [7:0] d;
      logic [7:0] p;
      m = v[7:0];
      d = v[15:8];
      p = v[23:16];
      periodicOk = (m == MODE_OFF) ||
                   ((m == MODE_LOW || m == MODE_HIGH) &&
                    d >= DUTY_MIN && d <= DUTY_MAX &&
                    p >= PERIOD_MIN && p <= PERIOD_MAX);
   endfunction

   // ==========================================================
   // configuration values and host answers
   logic        enableQ,   enableD;
   logic [31:0] optsQ,     optsD;
   logic [7:0]  modeQ,     modeD;
   logic [7:0]  dutyQ,     dutyD;
   logic [7:0]  periodQ,   periodD;
   logic [7:0]  dirWidthQ, dirWidthD;
   logic        rspValidQ, rspValidD;
   logic        rspStatusQ, rspStatusD;
   logic [2:0]  rspLenQ,   rspLenD;
   logic [31:0] rspDataQ,  rspDataD;

   always_comb begin
      enableD    = enableQ;
      optsD      = optsQ;
      modeD      = modeQ;
      dutyD      = dutyQ;
      periodD    = periodQ;
      dirWidthD  = dirWidthQ;
      rspValidD  = cmdValid;
      rspStatusD = STATUS_OK;
      rspLenD    = 3'h0;
      rspDataD   = 32'h00000000;
      if (cmdValid) begin
         case (cmdId)
            ID_ENABLE: begin
               rspLenD = LEN_ENABLE;
               if (cmdWrite && (cmdLen != LEN_ENABLE ||
                                cmdData[7:1] != 7'h00)) begin
                  rspStatusD = STATUS_ERR;
               end else if (cmdWrite) begin
                  enableD = cmdData[0];
               end else begin
                  rspDataD = {31'h00000000, enableQ};
               end
            end
            ID_OPTIONS: begin
               rspLenD = LEN_OPTIONS;
               if (cmdWrite && cmdLen != LEN_OPTIONS) begin
                  rspStatusD = STATUS_ERR;
               end else if (cmdWrite) begin
                  // reserved bits never stored, so they read back zero
                  optsD = cmdData & OPT_WRITABLE;
               end else begin
                  rspDataD = optsQ;
               end
            end
            ID_PERIODIC: begin
               rspLenD = LEN_PERIODIC;
               if (cmdWrite && (cmdLen != LEN_PERIODIC ||
                                !periodicOk(cmdData[23:0]))) begin
                  rspStatusD = STATUS_ERR;
               end else if (cmdWrite) begin
                  modeD   = cmdData[7:0];
                  dutyD   = cmdData[15:8];
                  periodD = cmdData[23:16];
               end else begin
                  rspDataD = {8'h00, periodQ, dutyQ, modeQ};
               end
            end
            ID_DIR_PULSE: begin
               rspLenD = LEN_DIR;
               if (cmdWrite && cmdLen != LEN_DIR) begin
                  rspStatusD = STATUS_ERR;
               end else if (cmdWrite) begin
                  dirWidthD = cmdData[7:0];
               end else begin
                  rspDataD = {24'h000000, dirWidthQ};
               end
            end
            default: begin
               rspStatusD = STATUS_ERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         enableQ    <= 1'b0;
         optsQ      <= OPT_RESET;
         modeQ      <= MODE_OFF;
         dutyQ      <= DUTY_MIN;
         periodQ    <= PERIOD_MIN;
         dirWidthQ  <= DIR_RESET;
         rspValidQ  <= 1'b0;
         rspStatusQ <= STATUS_OK;
         rspLenQ    <= 3'h0;
         rspDataQ   <= 32'h00000000;
      end else begin
         enableQ    <= enableD;
         optsQ      <= optsD;
         modeQ      <= modeD;
         dutyQ      <= dutyD;
         periodQ    <= periodD;
         dirWidthQ  <= dirWidthD;
         rspValidQ  <= rspValidD;
         rspStatusQ <= rspStatusD;
         rspLenQ    <= rspLenD;
         rspDataQ   <= rspDataD;
      end
   end

   // ==========================================================
   // pin synchronisers: a change counts once stages 2 and 3 agree
   logic [2:0] grantSyncQ, holdSyncQ;
   logic       grantQ, grantD, grantPrevQ;
   logic       holdQ, holdD;

   always_comb begin
      grantD = (grantSyncQ[1] == grantSyncQ[2]) ? grantSyncQ[2] : grantQ;
      holdD  = (holdSyncQ[1] == holdSyncQ[2]) ? holdSyncQ[2] : holdQ;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         grantSyncQ <= 3'h0;
         holdSyncQ  <= 3'h0;
         grantQ     <= 1'b0;
         grantPrevQ <= 1'b0;
         holdQ      <= 1'b0;
      end else begin
         grantSyncQ <= {grantSyncQ[1:0], grantPin};
         holdSyncQ  <= {holdSyncQ[1:0], radioHoldOffPin};
         grantQ     <= grantD;
         grantPrevQ <= grantQ;
         holdQ      <= holdD;
      end
   end

   // ==========================================================
   // periodic request generator
   cxa_cfg_if pwmBus ();
   assign pwmBus.mode   = modeQ;
   assign pwmBus.duty   = dutyQ;
   assign pwmBus.period = periodQ;
   assign pwmBus.run    = enableQ && !optsQ[OPT_FORCE_HOLD];

   cxa_pwm_gen #(
      .STEP_CYCLES (HALF_MS_CYCLES)
   ) uPwm (
      .clk     (clk),
      .reset_n (reset_n),
      .cfg     (pwmBus.gen)
   );

   // ==========================================================
   // request, priority and radio controls
   logic       rxReqQ, rxReqD, rxPriQ, rxPriD;
   logic [2:0] ccaCntQ, ccaCntD;
   logic [1:0] macCntQ, macCntD;
   logic       requestQ, requestD, priorityQ, priorityD;
   logic       ackSupQ, ackSupD, abortQ, abortD, macHoldQ, macHoldD;
   logic [1:0] assertPt;
   logic       retryReq, escalate, holdActive;

   always_comb begin
      assertPt  = optsQ[OPT_ASSERT_LSB +: 2];
      holdActive = optsQ[OPT_HOLDOFF_IN] && holdQ;
      retryReq  = optsQ[OPT_RETRY_EN] && rxRetry;
      // set wins over the end-of-frame clear
      rxReqD = rxEnd ? 1'b0 : rxReqQ;
      rxPriD = rxEnd ? 1'b0 : rxPriQ;
      if ((assertPt == ASSERT_SYNC || assertPt == ASSERT_SPLIT)
          ? rxSync : rxAddrMatch) begin
         rxReqD = 1'b1;
      end
      if ((assertPt == ASSERT_SYNC) ? rxSync : rxAddrMatch) begin
         rxPriD = 1'b1;
      end
      ccaCntD = txDone ? 3'h0 : ccaCntQ;
      macCntD = txDone ? 2'h0 : macCntQ;
      if (ccaFail && ccaCntD != 3'h7) begin
         ccaCntD = ccaCntD + 3'h1;
      end
      if (macFail && macCntD != 2'h3) begin
         macCntD = macCntD + 2'h1;
      end
      escalate = reached(ccaCntQ, optsQ[OPT_CCA_TH_LSB +: 3]) ||
                 reached({1'b0, macCntQ},
                         {1'b0, optsQ[OPT_MAC_TH_LSB +: 2]});
      // force holdoff wins over every request source
      requestD = enableQ && !optsQ[OPT_FORCE_HOLD] &&
                 (txPending || rxReqQ || retryReq || pwmBus.pwmReq);
      priorityD = requestD &&
                  ((txPending && (optsQ[OPT_TX_HI] || escalate)) ||
                   (rxPriQ && optsQ[OPT_RX_HI]) ||
                   (retryReq && optsQ[OPT_RETRY_HI]) ||
                   pwmBus.pwmHigh);
      ackSupD = enableQ && optsQ[OPT_ACK_DIS] &&
                (!grantQ || holdActive || !reqSecured);
      abortD  = enableQ && optsQ[OPT_ABORT] && txActive &&
                grantPrevQ && !grantQ;
      // held until grant; when clear the radio's own backoff applies
      macHoldD = enableQ && optsQ[OPT_MAC_HOLD] && !grantQ;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rxReqQ    <= 1'b0;
         rxPriQ    <= 1'b0;
         ccaCntQ   <= 3'h0;
         macCntQ   <= 2'h0;
         requestQ  <= 1'b0;
         priorityQ <= 1'b0;
         ackSupQ   <= 1'b0;
         abortQ    <= 1'b0;
         macHoldQ  <= 1'b0;
      end else begin
         rxReqQ    <= rxReqD;
         rxPriQ    <= rxPriD;
         ccaCntQ   <= ccaCntD;
         macCntQ   <= macCntD;
         requestQ  <= requestD;
         priorityQ <= priorityD;
         ackSupQ   <= ackSupD;
         abortQ    <= abortD;
         macHoldQ  <= macHoldD;
      end
   end

   // ==========================================================
   // directional priority pulse, once per request
   cxa_dp_state_t dpStateQ, dpStateD;
   logic [7:0]    dpLeftQ, dpLeftD;
   logic [5:0]    usCntQ, usCntD;
   logic          dirPulseQ, dirPulseD;

   always_comb begin
      dpStateD = dpStateQ;
      dpLeftD  = dpLeftQ;
      usCntD   = usCntQ;
      unique case (dpStateQ)
         DP_IDLE: begin
            usCntD = 6'h00;
            if (requestQ && dirWidthQ != 8'h00) begin
               dpStateD = DP_ACTIVE;
               dpLeftD  = dirWidthQ;
            end
         end
         DP_ACTIVE: begin
            if (!requestQ) begin
               dpStateD = DP_IDLE;
            end else if (usCntQ == US_LAST) begin
               usCntD  = 6'h00;
               dpLeftD = dpLeftQ - 8'h01;
               if (dpLeftQ == 8'h01) begin
                  dpStateD = DP_DONE;
               end
            end else begin
               usCntD = usCntQ + 6'h01;
            end
         end
         DP_DONE: begin
            if (!requestQ) begin
               dpStateD = DP_IDLE;
            end
         end
         default: begin
            dpStateD = DP_IDLE;
         end
      endcase
      dirPulseD = (dpStateD == DP_ACTIVE);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dpStateQ  <= DP_IDLE;
         dpLeftQ   <= 8'h00;
         usCntQ    <= 6'h00;
         dirPulseQ <= 1'b0;
      end else begin
         dpStateQ  <= dpStateD;
         dpLeftQ   <= dpLeftD;
         usCntQ    <= usCntD;
         dirPulseQ <= dirPulseD;
      end
   end

   assign rspValid       = rspValidQ;
   assign rspStatus      = rspStatusQ;
   assign rspLen         = rspLenQ;
   assign rspData        = rspDataQ;
   assign requestOut     = requestQ;
   assign priorityOut    = priorityQ;
   assign dirPulseOut    = dirPulseQ;
   assign ackSuppress    = ackSupQ;
   assign txAbort        = abortQ;
   assign macHoldOff     = macHoldQ;
   assign retryTimeoutMs = optsQ[OPT_RETRY_LSB +: OPT_RETRY_W];

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_force_hold_quiet: assert property (optsQ[OPT_FORCE_HOLD] |=> !requestQ)
      else $error("request raised under force holdoff");
   a_disable_quiet: assert property (!enableQ |=> !requestQ && !priorityQ)
      else $error("arbitration signals while disabled");
   a_opts_reserved: assert property ((optsQ & ~OPT_WRITABLE) == 32'h0)
      else $error("reserved option bits set");
   a_ack_suppress: assert property (enableQ && optsQ[OPT_ACK_DIS] && !grantQ
      |=> ackSupQ) else $error("ack not suppressed without grant");
   a_abort_grant: assert property (abortQ |-> $past(optsQ[OPT_ABORT])
      && $past(grantPrevQ) && !$past(grantQ))
      else $error("abort without lost grant");
   a_mac_hold: assert property (enableQ && optsQ[OPT_MAC_HOLD]
      |=> macHoldQ == !$past(grantQ))
      else $error("mac holdoff not following grant");
   a_bad_pwm_kept: assert property (cmdValid && cmdWrite &&
      cmdId == ID_PERIODIC && !periodicOk(cmdData[23:0])
      |=> rspStatusQ == STATUS_ERR && $stable(dutyQ) && $stable(periodQ)
      && $stable(modeQ))
      else $error("bad periodic setting accepted");
   a_dp_zero_off: assert property (dirWidthQ == 8'h00 && dpStateQ == DP_IDLE
      |=> !dirPulseQ) else $error("pulse with zero width");
   a_answer_next: assert property (cmdValid |=> rspValidQ ##1 !rspValidQ
      || $past(cmdValid)) else $error("answer not one cycle");
   c_req_pri: cover property (requestQ && priorityQ);
   c_abort: cover property (txAbort);
   c_dir_pulse: cover property (dirPulseQ ##1 !dirPulseQ);
endmodule
`default_nettype wire

// *** tb/cxa_arb_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// arbiter stand-in
// grants a held request after a short wait; deny lets tests withdraw it
module cxa_arb_model #(
   parameter int LAG = 3
) (
   input  wire logic clk,
   input  wire logic requestIn,
   input  wire logic deny,
   output var  logic grant
);
   int waitQ;
   initial begin
      waitQ = 0;
      grant = 1'b0;
   end
   always @(posedge clk) begin
      waitQ <= requestIn ? waitQ + 1 : 0;
      grant <= requestIn && !deny && waitQ >= LAG;
   end
endmodule
`default_nettype wire

// *** tb/cxa_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module cxa_top_tb_top;
   import cxa_pkg::*;
   logic        clk = 1'b0;
   logic        resetN = 1'b0;
   logic        cmdValid = 1'b0;
   logic        cmdWrite = 1'b0;
   logic [7:0]  cmdId = 8'h00;
   logic [2:0]  cmdLen = 3'h0;
   logic [31:0] cmdData = 32'h0;
   logic        reqSecured = 1'b0;
   logic        txPending = 1'b0;
   logic        txActive = 1'b0;
   logic        rxSync = 1'b0;
   logic        rxAddrMatch = 1'b0;
   logic        rxEnd = 1'b0;
   logic        deny = 1'b0;
   logic        holdOff = 1'b0;
   logic        rxRetry = 1'b0;
   logic        ccaFail = 1'b0;
   logic        macFail = 1'b0;
   logic        txDone = 1'b0;
   logic        rspValid, rspStatus, grant, requestOut, priorityOut;
   logic        dirPulseOut, ackSuppress, txAbort, macHoldOff;
   logic [2:0]  rspLen;
   logic [31:0] rspData;
   logic [7:0]  retryTimeoutMs;
   logic [31:0] c[4];
   logic [31:0] bad[5] = '{32'h143281, 32'h140480, 32'h146080,
                          32'h093282, 32'hDB3282};
   int          fails = 0;
   int          samplesChecked = 0;
   int          cycles = 0;
   cxa_top #(.HALF_MS_CYCLES(4)) i_cxa_top (.clk(clk), .reset_n(resetN),
      .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdId(cmdId),
      .cmdLen(cmdLen), .cmdData(cmdData), .rspValid(rspValid),
      .rspStatus(rspStatus), .rspLen(rspLen), .rspData(rspData),
      .grantPin(grant), .radioHoldOffPin(holdOff), .reqSecured(reqSecured),
      .txPending(txPending), .txActive(txActive), .rxSync(rxSync),
      .rxAddrMatch(rxAddrMatch), .rxEnd(rxEnd), .rxRetry(rxRetry),
      .ccaFail(ccaFail), .macFail(macFail), .txDone(txDone),
      .requestOut(requestOut), .priorityOut(priorityOut),
      .dirPulseOut(dirPulseOut), .ackSuppress(ackSuppress),
      .txAbort(txAbort), .macHoldOff(macHoldOff),
      .retryTimeoutMs(retryTimeoutMs));
   cxa_arb_model i_cxa_arb_model (.clk(clk), .requestIn(requestOut),
      .deny(deny), .grant(grant));
   // ==========================================
   // clock and hang guard
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         wrap_up();
      end
   end
   // ==========================================
   // access tasks
   task automatic chk(input string nm, input logic [31:0] e, g);
      samplesChecked++;
      if (e !== g) begin
         fails++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   function automatic logic [2:0] idLen(input logic [7:0] id);
      case (id)
         ID_ENABLE:    idLen = LEN_ENABLE;
         ID_OPTIONS:   idLen = LEN_OPTIONS;
         ID_PERIODIC:  idLen = LEN_PERIODIC;
         ID_DIR_PULSE: idLen = LEN_DIR;
         default:      idLen = 3'h0;
      endcase
   endfunction
   // answer stands in the cycle after the taking edge
   task automatic cmd(input logic w, input logic [7:0] id,
                      input logic [2:0] ln, input logic [31:0] d);
      cmdValid = 1'b1;
      cmdWrite = w;
      cmdId = id;
      cmdLen = ln;
      cmdData = d;
      @(negedge clk);
      cmdValid = 1'b0;
      chk("valid", 32'h1, 32'(rspValid));
      chk("rsp len", 32'(idLen(id)), 32'(rspLen));
   endtask
   task automatic put(input logic [7:0] id, input logic [2:0] ln,
                      input logic [31:0] d, input logic st);
      cmd(1'b1, id, ln, d);
      chk("status", 32'(st), 32'(rspStatus));
      repeat (3) @(negedge clk);
   endtask
   task automatic get(input logic [7:0] id, input logic [31:0] e);
      cmd(1'b0, id, 3'h0, 32'h0);
      chk("data", e, rspData);
      // let an edge pass so a following call does not re-raise the strobe
      @(negedge clk);
   endtask
   task automatic tally(input int n);
      c = '{32'h0, 32'h0, 32'h0, 32'h0};
      repeat (n) begin
         @(negedge clk);
         c[0] += 32'(requestOut);
         c[1] += 32'(priorityOut);
         c[2] += 32'(dirPulseOut);
         c[3] += 32'(txAbort);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic wrap_up();
      $display("checked %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      repeat (8) @(negedge clk);
      resetN = 1'b1;
      @(negedge clk);
      get(ID_OPTIONS, 32'h0);
      get(ID_PERIODIC, 32'h000A0500);
      get(ID_DIR_PULSE, 32'h0);
      put(ID_OPTIONS, LEN_OPTIONS, OPT_WRITABLE, STATUS_OK);
      get(ID_OPTIONS, OPT_WRITABLE);
      chk("timeout", 32'hFF, 32'(retryTimeoutMs));
      put(8'h33, 3'h1, 32'h0, STATUS_ERR);
      chk("len", 32'h0, 32'(rspLen));
      put(ID_OPTIONS, 3'h3, 32'h0, STATUS_ERR);
      put(ID_ENABLE, LEN_ENABLE, 32'h2, STATUS_ERR);
      put(ID_PERIODIC, LEN_PERIODIC, 32'hDA5F82, STATUS_OK);
      foreach (bad[i])
         put(ID_PERIODIC, LEN_PERIODIC, bad[i], STATUS_ERR);
      get(ID_PERIODIC, 32'hDA5F82);
      $display("test config done");
      put(ID_ENABLE, LEN_ENABLE, 32'h1, STATUS_OK);
      put(ID_OPTIONS, LEN_OPTIONS, 32'h0, STATUS_OK);
      // period 10 x 4 cycles, half of it on
      put(ID_PERIODIC, LEN_PERIODIC, 32'h0A3282, STATUS_OK);
      tally(80);
      chk("pwm req", 32'd40, c[0]);
      chk("pwm pri", 32'd40, c[1]);
      put(ID_PERIODIC, LEN_PERIODIC, 32'h0A3280, STATUS_OK);
      tally(80);
      chk("low pri", 32'd0, c[1]);
      chk("low req", 32'd40, c[0]);
      put(ID_OPTIONS, LEN_OPTIONS, 32'h00010000, STATUS_OK);
      tally(80);
      chk("holdoff", 32'd0, c[0]);
      put(ID_PERIODIC, LEN_PERIODIC, 32'h0, STATUS_OK);
      $display("test periodic done");
      put(ID_OPTIONS, LEN_OPTIONS, 32'h00000400, STATUS_OK);
      put(ID_DIR_PULSE, LEN_DIR, 32'h1, STATUS_OK);
      txPending = 1'b1;
      tally(100);
      chk("tx pri", 32'h3, {30'h0, requestOut, priorityOut});
      chk("dir pulse", 32'd40, c[2]);
      txPending = 1'b0;
      $display("test transmit done");
      // tx high bit left clear while escalating
      put(ID_OPTIONS, LEN_OPTIONS, 32'h02200000, STATUS_OK);
      txPending = 1'b1;
      pulse(ccaFail);
      chk("cca one", 32'h2, {30'h0, requestOut, priorityOut});
      pulse(ccaFail);
      chk("cca two", 32'h3, {30'h0, requestOut, priorityOut});
      pulse(txDone);
      chk("tx done", 32'h2, {30'h0, requestOut, priorityOut});
      pulse(macFail);
      chk("mac fail", 32'h3, {30'h0, requestOut, priorityOut});
      txPending = 1'b0;
      $display("test escalate done");
      put(ID_OPTIONS, LEN_OPTIONS, 32'h00020300, STATUS_OK);
      deny = 1'b1;
      txPending = 1'b1;
      txActive = 1'b1;
      repeat (10) @(negedge clk);
      chk("mac hold", 32'h3, {30'h0, macHoldOff, ackSuppress});
      reqSecured = 1'b1;
      deny = 1'b0;
      repeat (12) @(negedge clk);
      chk("granted", 32'h0, {30'h0, macHoldOff, ackSuppress});
      deny = 1'b1;
      tally(12);
      chk("abort", 32'd1, c[3]);
      txPending = 1'b0;
      txActive = 1'b0;
      deny = 1'b0;
      $display("test grant done");
      put(ID_OPTIONS, LEN_OPTIONS, 32'h00080800, STATUS_OK);
      pulse(rxSync);
      chk("rx sync", 32'h2, {30'h0, requestOut, priorityOut});
      pulse(rxAddrMatch);
      chk("rx addr", 32'h3, {30'h0, requestOut, priorityOut});
      pulse(rxEnd);
      chk("rx end", 32'h0, {30'h0, requestOut, priorityOut});
      put(ID_OPTIONS, LEN_OPTIONS, 32'h00047900, STATUS_OK);
      pulse(rxSync);
      chk("addr point", 32'h0, {30'h0, requestOut, priorityOut});
      pulse(rxAddrMatch);
      chk("addr req", 32'h3, {30'h0, requestOut, priorityOut});
      pulse(rxEnd);
      rxRetry = 1'b1;
      repeat (14) @(negedge clk);
      chk("retry", 32'h3,
          {29'h0, ackSuppress, requestOut, priorityOut});
      holdOff = 1'b1;
      repeat (6) @(negedge clk);
      chk("hold off", 32'h7,
          {29'h0, ackSuppress, requestOut, priorityOut});
      rxRetry = 1'b0;
      holdOff = 1'b0;
      $display("test receive done");
      wrap_up();
   end
endmodule
`default_nettype wire
